// file: core/vic_pkg.sv
/*
 vic_pkg: constants, register indices, field positions, vectors and helper functions
 for the vectored interrupt controller.
 assumes: included by every core file through import vic_pkg::*.
*/
package vic_pkg;

	localparam int SRC_N = 6;
	localparam int SRC_IDX_W = 3;
	localparam int LVL_N = 4;
	localparam int LVL_W = 2;
	localparam int REG_W = 8;
	localparam int VEC_W = 16;
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	localparam int STAT_W = 16;

	// source positions, the same in enable and priority registers
	localparam int SRC_PIN0 = 0;
	localparam int SRC_TMR0 = 1;
	localparam int SRC_PIN1 = 2;
	localparam int SRC_TMR1 = 3;
	localparam int SRC_SER = 4;
	localparam int SRC_TMR2 = 5;

	localparam int IEN_GLOBAL = 7;

	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PRIO_HIGH = 10'h0B7;
	localparam logic [IDX_W-1:0] IDX_PRIO_LOW = 10'h0B8;
	localparam logic [IDX_W-1:0] IDX_IRQ_EN = 10'h0A0;
	localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0C0;
	localparam logic [IDX_W-1:0] IDX_CTRL = 10'h0C1;

	localparam logic [REG_W-1:0] RST_IRQ_EN = 8'h00;
	localparam logic [REG_W-1:0] RST_PRIO = 8'h00;
	localparam logic [REG_W-1:0] RST_CTRL = 8'h00;

	// reserved positions are kept at zero
	localparam logic [REG_W-1:0] IEN_WMASK = 8'hBF;
	localparam logic [REG_W-1:0] PRIO_WMASK = 8'h3F;
	localparam logic [REG_W-1:0] CTRL_WMASK = 8'h03;

	// control register: per-pin edge mode
	localparam int CTRL_PIN0_EDGE = 0;
	localparam int CTRL_PIN1_EDGE = 1;

	// status register fields
	localparam int STAT_POLL_LSB = 0;
	localparam int STAT_INSVC_LSB = 8;
	localparam int STAT_IDLE = 12;
	localparam int STAT_RAMBLK = 13;

	localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
	localparam logic [VEC_W-1:0] VEC_PIN0 = 16'h0003;
	localparam logic [VEC_W-1:0] VEC_TMR0 = 16'h000B;
	localparam logic [VEC_W-1:0] VEC_PIN1 = 16'h0013;
	localparam logic [VEC_W-1:0] VEC_TMR1 = 16'h001B;
	localparam logic [VEC_W-1:0] VEC_SER = 16'h0023;
	localparam logic [VEC_W-1:0] VEC_TMR2 = 16'h002B;

	// machine cycle: six states of two phases, slot = (state-1)*2 + (phase-1)
	localparam int CLKS_PER_MC_DEF = 12;
	localparam int SLOT_S5P2 = 9;
	localparam int RST_IDLE_MC = 2;

	typedef enum {VIC_RUN, VIC_IDLE, VIC_RSTWIN} vic_mode_e;

	function automatic logic [LVL_W-1:0] vic_lvl_of(input logic [REG_W-1:0] phi,
		input logic [REG_W-1:0] plo, input int i);
		return {phi[i], plo[i]};
	endfunction

	function automatic logic [VEC_W-1:0] vic_vec_of(input logic [SRC_IDX_W-1:0] idx);
		case (idx)
			3'h0: return VEC_PIN0;
			3'h1: return VEC_TMR0;
			3'h2: return VEC_PIN1;
			3'h3: return VEC_TMR1;
			3'h4: return VEC_SER;
			3'h5: return VEC_TMR2;
			default: return VEC_RESET;
		endcase
	endfunction

endpackage

// file: core/vic_if.sv
/*
 vic_if: carrier between the controller core, its register slave and its arbiter.
 assumes: all three modules run on the same clock.
*/
`timescale 1ns/1ps
interface vic_if;
	import vic_pkg::*;
	logic [REG_W-1:0] ien;
	logic [REG_W-1:0] plo;
	logic [REG_W-1:0] phi;
	logic [REG_W-1:0] ctrl;
	logic [STAT_W-1:0] status;
	logic [SRC_N-1:0] req;
	logic win_valid;
	logic [SRC_IDX_W-1:0] win_idx;
	logic [LVL_W-1:0] win_lvl;
	modport regs(output ien, plo, phi, ctrl, input status);
	modport arb(input req, phi, plo, output win_valid, win_idx, win_lvl);
	modport core(input ien, plo, phi, ctrl, win_valid, win_idx, win_lvl, output status, req);
endinterface

// file: core/vic_arb.sv
/*
 vic_arb: picks the highest level pending source, lowest index first within a level.
 assumes: req already gated by the enables.
*/
`timescale 1ns/1ps
module vic_arb import vic_pkg::*; (
	vic_if.arb bus
);
	// later hits override, so the highest level and lowest index win
	always_comb begin
		bus.win_valid = 1'b0;
		bus.win_idx = '0;
		bus.win_lvl = '0;
		for (int l = 0; l < LVL_N; l++) begin
			for (int i = SRC_N - 1; i >= 0; i--) begin
				if (bus.req[i] && vic_lvl_of(bus.phi, bus.plo, i) == l[LVL_W-1:0]) begin
					bus.win_valid = 1'b1;
					bus.win_idx = i[SRC_IDX_W-1:0];
					bus.win_lvl = l[LVL_W-1:0];
				end
			end
		end
	end
endmodule

// file: core/vic_apb.sv
/*
 vic_apb: APB slave holding enable, priority and control registers.
 assumes: APB master keeps request stable until pready; no wait states, pready is high in the first access cycle.
*/
`timescale 1ns/1ps
module vic_apb import vic_pkg::*; (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	vic_if.regs bus
);
	logic [IDX_W-1:0] idx;
	logic mapped;
	logic [REG_W-1:0] rd_val;
	logic wr_go;

	assign idx = paddr[ADDR_W-1:2];
	assign mapped = (paddr[1:0] == 2'h0) && (idx == IDX_PRIO_HIGH || idx == IDX_PRIO_LOW
		|| idx == IDX_IRQ_EN || idx == IDX_STATUS || idx == IDX_CTRL);
	assign wr_go = psel && penable && pready && pwrite && mapped;

	always_comb begin
		rd_val = '0;
		case (idx)
			IDX_IRQ_EN: rd_val = bus.ien;
			IDX_PRIO_LOW: rd_val = bus.plo;
			IDX_PRIO_HIGH: rd_val = bus.phi;
			IDX_CTRL: rd_val = bus.ctrl;
			default: rd_val = '0;
		endcase
	end

	// answer in the first access cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel && !penable && !pready;
			if (psel && !penable) begin
				pslverr <= !mapped;
				if (idx == IDX_STATUS)
					prdata <= {16'h0000, bus.status};
				else
					prdata <= {24'h000000, rd_val};
			end
		end
	end

	// reserved bits never store a one
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bus.ien <= RST_IRQ_EN;
			bus.plo <= RST_PRIO;
			bus.phi <= RST_PRIO;
			bus.ctrl <= RST_CTRL;
		end else if (wr_go) begin
			case (idx)
				IDX_IRQ_EN: bus.ien <= pwdata[REG_W-1:0] & IEN_WMASK;
				IDX_PRIO_LOW: bus.plo <= pwdata[REG_W-1:0] & PRIO_WMASK;
				IDX_PRIO_HIGH: bus.phi <= pwdata[REG_W-1:0] & PRIO_WMASK;
				IDX_CTRL: bus.ctrl <= pwdata[REG_W-1:0] & CTRL_WMASK;
				default: bus.ctrl <= bus.ctrl;
			endcase
		end
	end
endmodule

// file: core/vic_top.sv
/*
 vic_top: vectored interrupt controller with four priority levels, machine-cycle
 polling, in-service tracking and idle wake/reset handling.
 assumes: peripheral flags come from logic on mclk and are cleared by their owners;
 pins are asynchronous and synchronised here; the core acks a vector and signals return.
*/
`timescale 1ns/1ps
module vic_top import vic_pkg::*; #(
	parameter int CLKS_PER_MC = CLKS_PER_MC_DEF
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	input wire logic hw_reset_pin,
	input wire logic timer0_overflow_flag,
	input wire logic timer1_overflow_flag,
	input wire logic timer2_overflow_flag,
	input wire logic timer2_external_flag,
	input wire logic uart_rx_done,
	input wire logic uart_tx_done,
	input wire logic spi_done_flag,
	input wire logic spi_irq_gate,
	input wire logic cpu_irq_ack,
	input wire logic cpu_reti,
	input wire logic cpu_idle_enter,
	output logic irq_vector_valid,
	output logic [VEC_W-1:0] irq_vector_addr,
	output logic [LVL_W-1:0] irq_vector_level,
	output logic idle_active,
	output logic ram_access_block,
	output logic core_reset
);
	localparam int MC_W = $clog2(CLKS_PER_MC);
	localparam logic [MC_W-1:0] POLL_SLOT = MC_W'(CLKS_PER_MC - 1);
	localparam logic [MC_W-1:0] S5P2_SLOT = MC_W'(SLOT_S5P2);
	localparam logic [1:0] RSTWIN_LAST = 2'(RST_IDLE_MC - 1);

	vic_if bus();

	// register slave and arbiter
	vic_apb u_apb (
		.mclk(mclk),
		.arst_n(arst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.bus(bus)
	);

	vic_arb u_arb (
		.bus(bus)
	);

	logic [1:0] pin_s1;
	logic [1:0] pin_s2;
	logic [1:0] pin_d;
	logic rst_s1;
	logic rst_s2;
	logic [MC_W-1:0] mc_slot;
	logic mc_poll;
	logic [1:0] tmr01_snap;
	logic [1:0] tmr01_poll;
	logic [1:0] pin_flag;
	logic [1:0] pin_src;
	logic [1:0] pin_edge_mode;
	logic serial_req;
	logic timer2_req;
	logic [SRC_N-1:0] raw_src;
	logic [SRC_N-1:0] polled;
	logic [SRC_N-1:0] en_mask;
	logic [LVL_N-1:0] insvc;
	logic [LVL_N-1:0] next_insvc;
	logic [SRC_IDX_W-1:0] offer_idx;
	logic accept;
	logic above_lvl;
	logic ack_go;
	logic wake_req;
	logic [SRC_N-1:0] wake_src;
	vic_mode_e mode;
	vic_mode_e next_mode;
	logic [1:0] rst_mc_cnt;
	logic rstwin_done;

	function automatic logic [LVL_W-1:0] top_level(input logic [LVL_N-1:0] s);
		logic [LVL_W-1:0] r;
		r = '0;
		for (int l = 0; l < LVL_N; l++) begin
			if (s[l])
				r = l[LVL_W-1:0];
		end
		return r;
	endfunction

	// edge mode uses the latched flag, level mode a low pin
	function automatic logic pin_req(input logic edge_mode, input logic flag, input logic lvl);
		return edge_mode ? flag : !lvl;
	endfunction

	function automatic logic [SRC_IDX_W-1:0] pin_idx(input int n);
		return (n == 0) ? SRC_IDX_W'(SRC_PIN0) : SRC_IDX_W'(SRC_PIN1);
	endfunction

	// pin and reset synchronisers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1 <= 2'h3;
			pin_s2 <= 2'h3;
			pin_d <= 2'h3;
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			pin_s1 <= {ext_irq_pin_b, ext_irq_pin_a};
			pin_s2 <= pin_s1;
			pin_d <= pin_s2;
			rst_s1 <= hw_reset_pin;
			rst_s2 <= rst_s1;
		end
	end

	// machine cycle slot counter
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			mc_slot <= '0;
		else if (mc_poll)
			mc_slot <= '0;
		else
			mc_slot <= mc_slot + MC_W'(1);
	end

	assign mc_poll = (mc_slot == POLL_SLOT);

	// pin requests: low level, or latched falling edge cleared on vectoring
	assign pin_edge_mode = {bus.ctrl[CTRL_PIN1_EDGE], bus.ctrl[CTRL_PIN0_EDGE]};
	assign ack_go = irq_vector_valid && cpu_irq_ack;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pin_flag <= 2'h0;
		end else begin
			for (int n = 0; n < 2; n++) begin
				if (!pin_edge_mode[n])
					pin_flag[n] <= 1'b0;
				else if (pin_d[n] && !pin_s2[n])
					pin_flag[n] <= 1'b1;
				else if (ack_go && offer_idx == pin_idx(n))
					pin_flag[n] <= 1'b0;
			end
		end
	end

	assign pin_src[0] = pin_req(pin_edge_mode[0], pin_flag[0], pin_s2[0]);
	assign pin_src[1] = pin_req(pin_edge_mode[1], pin_flag[1], pin_s2[1]);

	// combined requests; flags belong to their peripherals and are never cleared here
	assign timer2_req = timer2_overflow_flag || timer2_external_flag;
	assign serial_req = uart_rx_done || uart_tx_done
		|| (spi_done_flag && spi_irq_gate);

	// timer 0/1 sampled at S5P2, handed to the poll of the following cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tmr01_snap <= 2'h0;
			tmr01_poll <= 2'h0;
		end else begin
			if (mc_slot == S5P2_SLOT)
				tmr01_snap <= {timer1_overflow_flag, timer0_overflow_flag};
			if (mc_poll)
				tmr01_poll <= tmr01_snap;
		end
	end

	always_comb begin
		raw_src = '0;
		raw_src[SRC_PIN0] = pin_src[0];
		raw_src[SRC_TMR0] = tmr01_poll[0];
		raw_src[SRC_PIN1] = pin_src[1];
		raw_src[SRC_TMR1] = tmr01_poll[1];
		raw_src[SRC_SER] = serial_req;
		raw_src[SRC_TMR2] = timer2_req;
	end

	// poll once per machine cycle at its last slot
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			polled <= '0;
		else if (mc_poll)
			polled <= raw_src;
	end

	assign en_mask = bus.ien[IEN_GLOBAL] ? bus.ien[SRC_N-1:0] : '0;
	assign bus.req = polled & en_mask;

	// offer only above the level now in service
	assign above_lvl = insvc == '0 || bus.win_lvl > top_level(insvc);
	assign accept = bus.win_valid && mode == VIC_RUN && !irq_vector_valid && !core_reset
		&& above_lvl;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_vector_valid <= 1'b0;
			irq_vector_addr <= VEC_RESET;
			irq_vector_level <= '0;
			offer_idx <= '0;
		end else if (core_reset) begin
			irq_vector_valid <= 1'b0;
			irq_vector_addr <= VEC_RESET;
			irq_vector_level <= '0;
		end else if (ack_go) begin
			irq_vector_valid <= 1'b0;
		end else if (accept) begin
			irq_vector_valid <= 1'b1;
			irq_vector_addr <= vic_vec_of(bus.win_idx);
			irq_vector_level <= bus.win_lvl;
			offer_idx <= bus.win_idx;
		end
	end

	// in-service levels: return clears the highest, an ack marks the offered level
	always_comb begin
		next_insvc = insvc;
		if (cpu_reti && insvc != '0)
			next_insvc[top_level(insvc)] = 1'b0;
		if (ack_go)
			next_insvc[irq_vector_level] = 1'b1;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			insvc <= '0;
		else if (core_reset)
			insvc <= '0;
		else
			insvc <= next_insvc;
	end

	// idle and reset window
	// timer 0/1 wake on the raw flag, their vector still waits for its poll
	always_comb begin
		wake_src = raw_src;
		wake_src[SRC_TMR0] = raw_src[SRC_TMR0] || timer0_overflow_flag;
		wake_src[SRC_TMR1] = raw_src[SRC_TMR1] || timer1_overflow_flag;
	end

	assign wake_req = |(wake_src & en_mask);
	assign rstwin_done = mode == VIC_RSTWIN && mc_poll && rst_mc_cnt == RSTWIN_LAST;

	always_comb begin
		next_mode = mode;
		case (mode)
			VIC_RUN: begin
				if (cpu_idle_enter && !rst_s2)
					next_mode = VIC_IDLE;
			end
			VIC_IDLE: begin
				if (rst_s2)
					next_mode = VIC_RSTWIN;
				else if (wake_req)
					next_mode = VIC_RUN;
			end
			VIC_RSTWIN: begin
				if (rstwin_done)
					next_mode = VIC_RUN;
			end
			default: next_mode = VIC_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			mode <= VIC_RUN;
		else
			mode <= next_mode;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			rst_mc_cnt <= 2'h0;
		else if (mode != VIC_RSTWIN)
			rst_mc_cnt <= 2'h0;
		else if (mc_poll)
			rst_mc_cnt <= rst_mc_cnt + 2'h1;
	end

	// idle and ram block outputs follow the next mode so they line up with it
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			idle_active <= 1'b0;
			ram_access_block <= 1'b0;
			core_reset <= 1'b0;
		end else begin
			idle_active <= next_mode == VIC_IDLE;
			ram_access_block <= next_mode == VIC_RSTWIN;
			core_reset <= rstwin_done || (rst_s2 && mode == VIC_RUN);
		end
	end

	// readable state
	always_comb begin
		bus.status = '0;
		bus.status[STAT_POLL_LSB +: SRC_N] = polled;
		bus.status[STAT_INSVC_LSB +: LVL_N] = insvc;
		bus.status[STAT_IDLE] = idle_active;
		bus.status[STAT_RAMBLK] = ram_access_block;
	end

endmodule

// file: verification/vic_props.sv
/*
 vic_props: port-level checks of the interrupt controller.
 assumes: bound into vic_top; register writes are mirrored from the apb port.
*/
`timescale 1ns/1ps
module vic_props import vic_pkg::*; #(
	parameter int CLKS_PER_MC = CLKS_PER_MC_DEF
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic timer0_overflow_flag,
	input wire logic timer1_overflow_flag,
	input wire logic timer2_overflow_flag,
	input wire logic timer2_external_flag,
	input wire logic uart_rx_done,
	input wire logic uart_tx_done,
	input wire logic spi_done_flag,
	input wire logic spi_irq_gate,
	input wire logic cpu_irq_ack,
	input wire logic irq_vector_valid,
	input wire logic [VEC_W-1:0] irq_vector_addr,
	input wire logic [LVL_W-1:0] irq_vector_level,
	input wire logic idle_active,
	input wire logic ram_access_block,
	input wire logic core_reset
);
	localparam int RW_MIN = 2;
	localparam int RW_MAX = 2 * CLKS_PER_MC + 2;
	logic [REG_W-1:0] ien, plo, phi;
	logic [REG_W-1:0] sel;
	logic wr, live;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign sel = 8'h01 << irq_vector_addr[5:3];
	// enabled timer or serial source seen without waiting for a poll
	assign live = ien[IEN_GLOBAL] && (ien[SRC_TMR0] && timer0_overflow_flag
		|| ien[SRC_TMR1] && timer1_overflow_flag
		|| ien[SRC_TMR2] && (timer2_overflow_flag || timer2_external_flag)
		|| ien[SRC_SER] && (uart_rx_done || uart_tx_done || spi_done_flag && spi_irq_gate));
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ien <= RST_IRQ_EN;
			plo <= RST_PRIO;
			phi <= RST_PRIO;
		end else if (wr) begin
			if (paddr[11:2] == IDX_IRQ_EN) ien <= pwdata[7:0] & IEN_WMASK;
			if (paddr[11:2] == IDX_PRIO_LOW) plo <= pwdata[7:0] & PRIO_WMASK;
			if (paddr[11:2] == IDX_PRIO_HIGH) phi <= pwdata[7:0] & PRIO_WMASK;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_vec_table: assert property (irq_vector_valid |-> irq_vector_addr[2:0] == 3'h3
		&& irq_vector_addr[15:6] == 10'h000 && irq_vector_addr[5:3] <= 3'h5)
		else $error("vector outside table");
	a_global_gate: assert property ($rose(irq_vector_valid) |-> $past(ien[IEN_GLOBAL]))
		else $error("vector with global enable off");
	a_src_enable: assert property ($rose(irq_vector_valid) |-> |($past(ien) & sel))
		else $error("vector of disabled source");
	a_level_match: assert property ($rose(irq_vector_valid) |-> irq_vector_level ==
		{|($past(phi) & sel), |($past(plo) & sel)}) else $error("wrong vector level");
	a_offer_hold: assert property (irq_vector_valid && !cpu_irq_ack && !core_reset |=>
		core_reset || irq_vector_valid && $stable(irq_vector_addr)) else $error("offer lost");
	a_ack_drop: assert property (irq_vector_valid && cpu_irq_ack |=> !irq_vector_valid)
		else $error("offer kept after ack");
	a_idle_wake: assert property (idle_active && live && !ram_access_block |=> !idle_active)
		else $error("idle not ended by request");
	a_rst_window: assert property ($rose(ram_access_block) |->
		##[RW_MIN:RW_MAX] $fell(ram_access_block)) else $error("ram block window length");
	a_blk_reset: assert property ($fell(ram_access_block) |-> core_reset)
		else $error("ram block ended without core reset");
	c_offer: cover property ($rose(irq_vector_valid));
	c_wake: cover property ($fell(idle_active));
	c_rst_win: cover property ($fell(ram_access_block));
endmodule

bind vic_top vic_props #(.CLKS_PER_MC(CLKS_PER_MC)) u_props (.*);

// file: verification/vic_cpu_model.sv
/*
 vic_cpu_model: core side, takes each offered vector after a set wait.
 assumes: same clock as the controller; service ends are issued by the bench.
*/
`timescale 1ns/1ps
module vic_cpu_model (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [3:0] ack_wait,
	input wire logic irq_vector_valid,
	output logic cpu_irq_ack
);
	logic [3:0] cnt;
	// ack only while a vector is offered
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 4'h0;
			cpu_irq_ack <= 1'b0;
		end else if (irq_vector_valid && !cpu_irq_ack && cnt >= ack_wait) begin
			cpu_irq_ack <= 1'b1;
			cnt <= 4'h0;
		end else begin
			cpu_irq_ack <= 1'b0;
			cnt <= (irq_vector_valid && !cpu_irq_ack) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// file: verification/testbench.sv
/*
 testbench: register, vector, priority and idle tests over apb.
 assumes: vic_top with bound checker, vic_cpu_model as the core.
*/
`timescale 1ns/1ps
module testbench import vic_pkg::*;;
	localparam int MC = 12;
	logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic ext_irq_pin_a, ext_irq_pin_b, hw_reset_pin, spi_done_flag, spi_irq_gate;
	logic timer0_overflow_flag, timer1_overflow_flag, timer2_overflow_flag;
	logic timer2_external_flag, uart_rx_done, uart_tx_done, cpu_irq_ack;
	logic cpu_reti, cpu_idle_enter, irq_vector_valid, idle_active, ram_access_block;
	logic core_reset, seen;
	logic [VEC_W-1:0] irq_vector_addr;
	logic [LVL_W-1:0] irq_vector_level;
	logic [3:0] ack_wait;
	logic [VEC_W-1:0] vec_tab [SRC_N] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B,
		16'h0023, 16'h002B};
	int bad_count, n_compared, cyc, n;
	vic_top #(.CLKS_PER_MC(MC)) dut (.*);
	vic_cpu_model cpu (.*);
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string w);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [IDX_W-1:0] i, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rchk(input logic [IDX_W-1:0] i, input logic [31:0] e, input string w);
		apb(1'b0, i, 32'h0);
		cmp(rd, e, w);
	endtask
	task automatic wait_vec(input logic [VEC_W-1:0] e, input string w);
		n = 0;
		while (irq_vector_valid !== 1'b1 && n < 5 * MC) begin
			@(posedge mclk);
			n++;
		end
		cmp({15'h0, irq_vector_valid, irq_vector_addr}, {16'h1, e}, w);
		// let the core take the offer before the next step
		n = 0;
		while (irq_vector_valid === 1'b1 && n < 2 * MC) begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic no_vec(input string w);
		seen = 1'b0;
		repeat (3 * MC) begin
			@(posedge mclk);
			seen |= irq_vector_valid;
		end
		cmp({31'h0, seen}, 32'h0, w);
	endtask
	task automatic reti;
		repeat (3 * MC) @(posedge mclk);
		cpu_reti <= 1'b1;
		@(posedge mclk);
		cpu_reti <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic idle_in;
		cpu_idle_enter <= 1'b1;
		@(posedge mclk);
		cpu_idle_enter <= 1'b0;
		repeat (2) @(posedge mclk);
		cmp({31'h0, idle_active}, 32'h1, "idle entered");
	endtask
	task automatic set_src(input int i, input logic v);
		case (i)
			SRC_PIN0: ext_irq_pin_a <= !v;
			SRC_TMR0: timer0_overflow_flag <= v;
			SRC_PIN1: ext_irq_pin_b <= !v;
			SRC_TMR1: timer1_overflow_flag <= v;
			SRC_SER: uart_tx_done <= v;
			default: timer2_overflow_flag <= v;
		endcase
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, hw_reset_pin, cpu_reti} = '0;
		{timer0_overflow_flag, timer1_overflow_flag, timer2_overflow_flag} = '0;
		{timer2_external_flag, uart_rx_done, uart_tx_done, spi_done_flag} = '0;
		{spi_irq_gate, cpu_idle_enter, ack_wait} = '0;
		{ext_irq_pin_a, ext_irq_pin_b} = 2'b11;
		arst_n = 1'b0;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		rchk(IDX_IRQ_EN, 32'h0, "enable reset");
		rchk(IDX_PRIO_LOW, 32'h0, "prio low reset");
		rchk(IDX_PRIO_HIGH, 32'h0, "prio high reset");
		apb(1'b1, IDX_IRQ_EN, 32'hBF);
		apb(1'b1, IDX_PRIO_LOW, 32'hFF);
		apb(1'b1, IDX_PRIO_HIGH, 32'hFF);
		rchk(IDX_IRQ_EN, 32'hBF, "enable bits");
		rchk(IDX_PRIO_LOW, 32'h3F, "prio low unused");
		rchk(IDX_PRIO_HIGH, 32'h3F, "prio high unused");
		rchk(10'h3FF, 32'h0, "unmapped read");
		cmp({31'h0, err}, 32'h1, "unmapped error");
		apb(1'b1, IDX_PRIO_LOW, 32'h0);
		apb(1'b1, IDX_PRIO_HIGH, 32'h0);
		$display("registers test done");
		for (int i = 0; i < SRC_N; i++) begin
			apb(1'b1, IDX_IRQ_EN, 32'h1 << i);
			set_src(i, 1'b1);
			no_vec("global off");
			apb(1'b1, IDX_IRQ_EN, 32'h80 | (32'h1 << i));
			wait_vec(vec_tab[i], "vector");
			set_src(i, 1'b0);
			reti();
		end
		apb(1'b1, IDX_IRQ_EN, 32'h90);
		spi_done_flag <= 1'b1;
		no_vec("spi gate off");
		spi_irq_gate <= 1'b1;
		wait_vec(16'h0023, "spi vector");
		spi_done_flag <= 1'b0;
		reti();
		$display("vectors test done");
		apb(1'b1, IDX_IRQ_EN, 32'hB0);
		ack_wait <= 4'h5;
		uart_rx_done <= 1'b1;
		timer2_external_flag <= 1'b1;
		wait_vec(16'h0023, "equal level order");
		uart_rx_done <= 1'b0;
		no_vec("level in service");
		rchk(IDX_STATUS, 32'h120, "status pending");
		reti();
		wait_vec(16'h002B, "timer2 external");
		timer2_external_flag <= 1'b0;
		reti();
		apb(1'b1, IDX_PRIO_HIGH, 32'h20);
		uart_rx_done <= 1'b1;
		wait_vec(16'h0023, "low level first");
		uart_rx_done <= 1'b0;
		repeat (2 * MC) @(posedge mclk);
		timer2_overflow_flag <= 1'b1;
		wait_vec(16'h002B, "preempt");
		timer2_overflow_flag <= 1'b0;
		reti();
		reti();
		$display("priority test done");
		apb(1'b1, IDX_CTRL, 32'hFF);
		rchk(IDX_CTRL, 32'h3, "ctrl mask");
		apb(1'b1, IDX_IRQ_EN, 32'h81);
		ext_irq_pin_a <= 1'b0;
		repeat (3) @(posedge mclk);
		ext_irq_pin_a <= 1'b1;
		wait_vec(16'h0003, "pin edge latch");
		reti();
		no_vec("pin edge cleared");
		$display("edge test done");
		apb(1'b1, IDX_IRQ_EN, 32'hA0);
		idle_in();
		timer2_external_flag <= 1'b1;
		repeat (3) @(posedge mclk);
		cmp({31'h0, idle_active}, 32'h0, "wake");
		wait_vec(16'h002B, "wake vector");
		timer2_external_flag <= 1'b0;
		reti();
		idle_in();
		hw_reset_pin <= 1'b1;
		seen = 1'b0;
		n = 0;
		while (core_reset !== 1'b1 && n < 4 * MC) begin
			@(posedge mclk);
			seen |= ram_access_block;
			n++;
		end
		cmp({30'h0, seen, core_reset}, 32'h3, "reset window");
		hw_reset_pin <= 1'b0;
		repeat (2) @(posedge mclk);
		cmp({14'h0, idle_active, irq_vector_valid, irq_vector_addr}, 32'h0, "reset");
		$display("idle test done");
		final_report();
	end
endmodule
